// [inc/blank_pkg.sv]
/*
 * Types for the trip blanking window filter.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package blank_pkg;
    typedef enum logic [2:0] {
        WIN_IDLE  = 3'b001,
        WIN_DELAY = 3'b010,
        WIN_OPEN  = 3'b100
    } win_state_t;
endpackage
`default_nettype wire

// [inc/blank_regs.svh]
/*
 * Timing counts and reset values for the trip blanking window filter.
 * Assumes inclusion by bare name from design files.
 */
`ifndef BLANK_REGS_SVH
`define BLANK_REGS_SVH

`define BLANK_LATE_MASK_CYC 3
`define BLANK_GLITCH_LATE_CYC 3
`define BLANK_GLITCH_EARLY_CYC 1
`define BLANK_CNT_RESET 16'h0000

`endif

// [src/blank_sync.sv]
/*
 * Two-flop reset release synchroniser.
 * Assumes rst_n is asynchronous, active low.
 */
`default_nettype none
module blank_sync (
    input wire logic clk_sys,
    input wire logic rst_n,
    output logic rst_sync_n
);
    logic [1:0] stage_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stage_r <= 2'h0;
        end else begin
            stage_r <= {stage_r[0], 1'b1};
        end
    end
    assign rst_sync_n = stage_r[1];
endmodule
`default_nettype wire

// [src/trip_blanking_window.sv]
/*
 * Compare-event filter with blanking window, modelling the late mask
 * at window open and the glitch-prone window close.
 * Assumes synchronous inputs on clk_sys; configuration held static
 * while a window is in progress.
 */
`default_nettype none
`include "blank_regs.svh"

// Function
// [R1] Open window suppresses compare trip events
// [R2] First three cycles after opening pass events
// [R3] Filtered output follows raw events meanwhile
// [R4] Filtered event drives all enabled consumers
// [R5] Short trip after close may glitch output
// [R6] Glitch span: one before, three after close
// [R7] Window persists across period boundary
// [R8] Software opens window three cycles early
// [R9] Software sizes window away from trip ends
// [R10] Offset and width counted from counter event
// [R11] Filter disabled routes raw event unchanged
module trip_blanking_window #(
    parameter int CNT_W = 16,
    parameter int NUM_EVT = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [NUM_EVT-1:0] raw_compare_events,
    input wire logic [NUM_EVT-1:0] evt_select,
    input wire logic period_event,
    input wire logic filter_enable,
    input wire logic blank_enable,
    input wire logic [CNT_W-1:0] blank_offset,
    input wire logic [CNT_W-1:0] blank_width,
    input wire logic [3:0] consumer_enable,
    output logic filtered_compare_event,
    output logic trip_zone_logic,
    output logic trip_irq,
    output logic conv_soc,
    output logic out_force,
    output logic window_open,
    output logic close_hazard
);
    // Two counter bits at least, so the three-cycle late mask fits
    if (CNT_W < 2 || CNT_W > 32 || NUM_EVT < 1) begin
        $error("trip_blanking_window: unsupported parameters");
    end

    // Late mask length is a silicon property, deliberately not a port
    localparam logic [CNT_W-1:0] LATE_CYC = CNT_W'(`BLANK_LATE_MASK_CYC);
    localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

    typedef struct packed {
        blank_pkg::win_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] open_age;
        logic filt;
        logic [3:0] cons;
        logic [2:0] since_close;
        logic raw_prev;
        logic hazard;
    } state_t;

    state_t s_r;
    state_t s_nxt;
    logic rst_sync_n;
    logic raw_sel;
    logic masking;

    blank_sync u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .rst_sync_n(rst_sync_n)
    );

    assign raw_sel = |(raw_compare_events & evt_select);
    // Mask is late: only after the open window has aged three cycles
    assign masking = (s_r.st == blank_pkg::WIN_OPEN) &&
                     (s_r.open_age >= LATE_CYC); // see [R2]

    always_comb begin
        s_nxt = s_r;
        s_nxt.raw_prev = raw_sel;
        case (s_r.st)
            blank_pkg::WIN_IDLE: begin
                if (blank_enable && period_event) begin // see [R10]
                    s_nxt.cnt = blank_offset;
                    s_nxt.st = (blank_offset == '0) ? blank_pkg::WIN_OPEN
                                                    : blank_pkg::WIN_DELAY;
                    s_nxt.open_age = '0;
                    if (blank_offset == '0) begin
                        s_nxt.cnt = blank_width;
                    end
                end
            end
            blank_pkg::WIN_DELAY: begin
                if (s_r.cnt <= ONE) begin
                    s_nxt.st = blank_pkg::WIN_OPEN;
                    s_nxt.cnt = blank_width;
                    s_nxt.open_age = '0;
                end else begin
                    s_nxt.cnt = s_r.cnt - ONE;
                end
            end
            blank_pkg::WIN_OPEN: begin
                // Period events ignored here so the window spans the boundary
                if (s_r.cnt <= ONE) begin // see [R7]
                    s_nxt.st = blank_pkg::WIN_IDLE;
                    s_nxt.since_close = 3'h0;
                end else begin
                    s_nxt.cnt = s_r.cnt - ONE;
                end
                if (s_r.open_age < LATE_CYC) begin
                    s_nxt.open_age = s_r.open_age + ONE;
                end
            end
            default: begin
                s_nxt.st = blank_pkg::WIN_IDLE;
            end
        endcase
        // Saturates so a long idle never wraps into the glitch span
        if (s_r.st != blank_pkg::WIN_OPEN && s_r.since_close != 3'h7) begin
            s_nxt.since_close = s_r.since_close + 3'h1;
        end
        // Trip ending near the close edge: flag the glitch-prone case
        s_nxt.hazard = s_r.raw_prev && !raw_sel && filter_enable &&
                       ((s_r.st == blank_pkg::WIN_OPEN && s_r.cnt <= ONE &&
                         `BLANK_GLITCH_EARLY_CYC >= 1) ||
                        (s_r.st != blank_pkg::WIN_OPEN &&
                         s_r.since_close < 3'(`BLANK_GLITCH_LATE_CYC))); // see [R5] [R6]
        if (filter_enable) begin
            s_nxt.filt = raw_sel && !(blank_enable && masking); // see [R1] [R3]
        end else begin
            s_nxt.filt = raw_sel; // see [R11]
        end
        s_nxt.cons = consumer_enable & {4{s_nxt.filt}}; // see [R4]
    end

    // One register for all state keeps the reset values in one place
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_r <= '{st: blank_pkg::WIN_IDLE, cnt: CNT_W'(`BLANK_CNT_RESET),
                     open_age: '0, filt: 1'b0, cons: 4'h0,
                     since_close: 3'h7, raw_prev: 1'b0, hazard: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign filtered_compare_event = s_r.filt;
    assign trip_zone_logic = s_r.cons[0];
    assign trip_irq = s_r.cons[1];
    assign conv_soc = s_r.cons[2];
    // Short trip just after close reaches the output stage unfiltered
    assign out_force = s_r.cons[3]; // see [R5]
    assign window_open = (s_r.st == blank_pkg::WIN_OPEN);
    assign close_hazard = s_r.hazard;

    // Filter and window timing
    AST_MASKED: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // see [R1]
        (masking && filter_enable && blank_enable) |=> !filtered_compare_event)
        else $error("event passed while window masked");

    AST_UNMASKED: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // see [R1]
        !(masking && filter_enable && blank_enable) |=> (filtered_compare_event == $past(raw_sel)))
        else $error("event lost outside the masked span");

    AST_LATE3: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // see [R2]
        ($rose(window_open) && filter_enable) |=> (filtered_compare_event
            == $past(raw_sel)))
        else $error("early window cycle did not pass event");

    AST_LATE_PASS: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // see [R2]
        (window_open && s_r.open_age < LATE_CYC && raw_sel) |=> filtered_compare_event)
        else $error("late window cycle blocked a raw event");

    AST_FOLLOW: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // see [R3]
        (window_open && s_r.open_age < LATE_CYC) |=> (filtered_compare_event ==
            $past(raw_sel)))
        else $error("filtered event did not follow raw");

    AST_CONS: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // see [R4]
        trip_zone_logic |-> (filtered_compare_event && $past(consumer_enable[0])))
        else $error("trip zone driven without filtered event");

    AST_CONS_ALL: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // see [R4]
        {out_force, conv_soc, trip_irq, trip_zone_logic} ==
            ({4{filtered_compare_event}} & $past(consumer_enable)))
        else $error("consumer outputs differ from enabled filtered event");

    AST_BYPASS: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // see [R11]
        !filter_enable |=> (filtered_compare_event == $past(raw_sel)))
        else $error("bypass did not pass raw event");

    AST_SPAN: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // see [R7]
        (window_open && s_r.cnt > ONE && period_event) |=> window_open)
        else $error("window cut at period boundary");

    AST_IDLE_START: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // see [R10]
        (s_r.st == blank_pkg::WIN_IDLE && blank_enable && period_event &&
         blank_offset != '0) |=> (s_r.st == blank_pkg::WIN_DELAY))
        else $error("period event did not start the offset count");

    AST_OFFSET: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // see [R10]
        (s_r.st == blank_pkg::WIN_IDLE && blank_enable && period_event &&
         blank_offset == CNT_W'(2)) |-> ##3 window_open)
        else $error("window opened at wrong offset");

    AST_CLOSE: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // see [R10]
        (window_open && s_r.cnt <= ONE) |=> !window_open)
        else $error("window outlived its width");

    // Glitch-span flag
    AST_HAZARD: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // see [R6]
        close_hazard |-> $past(filter_enable))
        else $error("hazard flagged without filtering");

    AST_HAZ_AFTER: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // see [R5]
        (filter_enable && !window_open && s_r.raw_prev && !raw_sel &&
         s_r.since_close < 3'(`BLANK_GLITCH_LATE_CYC)) |=> close_hazard)
        else $error("trip end just after close not flagged");

    AST_HAZ_CAUSE: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // see [R6]
        close_hazard |-> ($past(s_r.raw_prev) && !$past(raw_sel)))
        else $error("hazard flagged without a trip ending");
endmodule
`default_nettype wire

// [test/power_stage.sv]
/*
 * Power stage model: counts forced trip actions on the modulated output.
 * Assumes out_force is a registered level on clk_sys.
 */
`default_nettype none
module power_stage (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic out_force,
    output var int trips
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev_r;
    // Each rising edge shuts the stage down once
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= 1'b0;
            trips <= 0;
        end else begin
            prev_r <= out_force;
            if (out_force && !prev_r) trips <= trips + 1;
        end
    end
endmodule
`default_nettype wire

// [test/pwm_trip_blanking_window_tb.sv]
/*
 * Self-checking bench for the trip blanking window filter.
 * Assumes the design files and the power stage model are compiled first.
 */
`default_nettype none
module pwm_trip_blanking_window_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rst_n = 0, per = 0, fen = 0, ben = 0;
    logic [3:0] raw = 4'h0, sel = 4'h1, cen = 4'hf;
    logic [15:0] off = 16'h0002, wid = 16'h0010;
    logic filt, zone, irq, soc, frc, wo, hz;
    int failures = 0, checks = 0, trips, n;
    initial forever #2.5 clk_sys = ~clk_sys;
    trip_blanking_window dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .raw_compare_events(raw), .evt_select(sel), .period_event(per),
        .filter_enable(fen), .blank_enable(ben), .blank_offset(off),
        .blank_width(wid), .consumer_enable(cen),
        .filtered_compare_event(filt), .trip_zone_logic(zone), .trip_irq(irq),
        .conv_soc(soc), .out_force(frc), .window_open(wo), .close_hazard(hz));
    power_stage stage (.clk_sys(clk_sys), .rst_n(rst_n), .out_force(frc),
        .trips(trips));
    task chk(input string nm, input logic [3:0] e, input logic [3:0] s);
        checks++;
        if (s !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task report_and_stop;
        if (failures == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task t_bypass;
        @(posedge clk_sys) raw <= 4'h1;
        repeat (3) @(negedge clk_sys);
        chk("consumers", 4'hf, {frc, soc, irq, zone});
        chk("stage", 4'h1, 4'(trips));
        @(posedge clk_sys) cen <= 4'h5;
        repeat (2) @(negedge clk_sys);
        chk("masked consumers", 4'h5, {frc, soc, irq, zone});
        @(posedge clk_sys) sel <= 4'h2;
        repeat (2) @(negedge clk_sys);
        chk("unselected", 4'h0, {3'h0, filt});
        @(posedge clk_sys) sel <= 4'h1;
        cen <= 4'hf;
    endtask
    // Waits for window_open to reach lvl, bounded
    task wait_wo(input logic lvl);
        n = 0;
        while (wo !== lvl && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
    endtask
    task t_window;
        @(posedge clk_sys) fen <= 1;
        ben <= 1;
        per <= 1;
        @(posedge clk_sys) per <= 0;
        wait_wo(1);
        chk("open delay", 4'h3, 4'(n));
        @(posedge clk_sys) raw <= 4'h0;
        @(negedge clk_sys);
        chk("late pass", 4'h1, {3'h0, filt});
        @(negedge clk_sys);
        chk("late follow", 4'h0, {3'h0, filt});
        @(posedge clk_sys) raw <= 4'h1;
        per <= 1;
        @(posedge clk_sys) per <= 0;
        repeat (4) @(negedge clk_sys);
        chk("blanked", 4'h0, {3'h0, filt});
        chk("spans period", 4'h1, {3'h0, wo});
        wait_wo(0);
        repeat (2) @(negedge clk_sys);
        chk("after close", 4'h1, {3'h0, filt});
    endtask
    // Trip ends right after close, inside the glitch span
    task t_hazard;
        @(posedge clk_sys) per <= 1;
        @(posedge clk_sys) per <= 0;
        wait_wo(1);
        wait_wo(0);
        @(posedge clk_sys) raw <= 4'h0;
        n = 0;
        repeat (6) begin
            @(negedge clk_sys);
            if (hz === 1'b1) n++;
        end
        chk("close hazard", 4'h1, 4'(n));
        // Workaround: trip ends well clear of the close edge
        @(posedge clk_sys) raw <= 4'h1;
        per <= 1;
        @(posedge clk_sys) per <= 0;
        wait_wo(1);
        wait_wo(0);
        repeat (4) @(posedge clk_sys);
        raw <= 4'h0;
        n = 0;
        repeat (6) begin
            @(negedge clk_sys);
            if (hz === 1'b1) n++;
        end
        chk("clear of close", 4'h0, 4'(n));
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1;
        repeat (3) @(posedge clk_sys);
        t_bypass;
        t_window;
        t_hazard;
        report_and_stop;
    end
    initial begin
        #5000;
        failures++;
        report_and_stop;
    end
endmodule
`default_nettype wire
